/* File: rtl/tpw_pkg.sv */
// shared constants and carrier types for the transmit partition write port
package tpw_pkg;

    localparam int TPW_PARTS = 8;            // virtual fifo partitions per buffer ram
    localparam int TPW_PSEL_W = 3;           // partition select width
    localparam int TPW_WORD_W = 32;          // write word width
    localparam int TPW_LANES = 4;            // words per buffer line
    localparam int TPW_LANE_IDX_W = 2;       // word index within a line
    localparam int TPW_LINE_W = 128;         // buffer line width
    localparam int TPW_PORT_W = 8;           // logical port number width
    localparam int TPW_MASK_W = 4;           // byte valid mask width
    localparam int TPW_WCNT_W = 3;           // words held in a line, 0 to 4
    localparam int TPW_LINES_DEF = 16;       // lines per partition
    localparam int TPW_FULL_THRESH_DEF = 12; // full once occupancy passes this
    localparam int TPW_CLK_PERIOD_NS = 5;    // clk_sys period at 200 MHz

    localparam logic [3:0] TPW_MASK_ALL = 4'hF;   // four bytes valid
    localparam logic [3:0] TPW_MASK_THREE = 4'hE; // three bytes, end in third
    localparam logic [3:0] TPW_MASK_ONE = 4'h8;   // one byte, end in first
    localparam logic [3:0] TPW_MASK_NONE = 4'h0;  // nothing valid, drop the word
    localparam logic [1:0] TPW_LAST_LANE = 2'h3;  // index of the fourth word

    // descriptor stored beside every committed line
    typedef struct packed {
        logic [TPW_PORT_W-1:0] port;
        logic start;
        logic stop;
        logic err;
        logic [TPW_MASK_W-1:0] last_mask;
        logic [TPW_WCNT_W-1:0] words;
    } tpw_meta_t;

    // one sampled write request
    typedef struct packed {
        logic [TPW_PSEL_W-1:0] part;
        logic [TPW_WORD_W-1:0] word;
        logic [TPW_MASK_W-1:0] mask;
        logic start;
        logic stop;
        logic err;
        logic [TPW_PORT_W-1:0] port;
    } tpw_wr_t;

endpackage : tpw_pkg

/* File: rtl/tpw_line_store.sv */
// line-wide buffer ram with per-lane write enables and a registered read
`timescale 1ns/1ps
module tpw_line_store
    import tpw_pkg::*;
#(
    parameter int AW = 7,
    parameter int LANES = 4,
    parameter int LANE_W = 32
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [LANES-1:0] wr_lane_en,
    input wire logic [LANE_W-1:0] wr_word,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [LANES*LANE_W-1:0] rd_line_q
);

    ////////////////////////////////////////////////////////////////////////////////
    // one array per lane so a single word lands without a read-modify-write
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_W-1:0] mem [2**AW];

            // memory has no reset; only committed lines are ever read back
            always_ff @(posedge clk_sys) begin
                if (clk_en && wr_en && wr_lane_en[g]) begin
                    mem[wr_addr] <= wr_word;
                end
            end

            // read register is reset so the output is defined from the start
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    rd_line_q[g*LANE_W +: LANE_W] <= '0;
                end else if (clk_en && rd_en) begin
                    rd_line_q[g*LANE_W +: LANE_W] <= mem[rd_addr];
                end
            end
        end
    endgenerate

endmodule : tpw_line_store

/* File: rtl/tpw_write_port.sv */
// write side of one transmit buffer ram with partition pointers and drain port
`timescale 1ns/1ps
module tpw_write_port
    import tpw_pkg::*;
#(
    parameter int LINES = TPW_LINES_DEF,
    parameter int FULL_THRESH = TPW_FULL_THRESH_DEF
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic tx_word_write_strobe,
    input wire logic [TPW_PSEL_W-1:0] tx_partition_select,
    input wire logic [TPW_WORD_W-1:0] tx_write_word,
    input wire logic [TPW_MASK_W-1:0] tx_byte_valid_mask,
    input wire logic tx_packet_start_flag,
    input wire logic tx_packet_end_flag,
    input wire logic tx_packet_error_flag,
    input wire logic [TPW_PORT_W-1:0] tx_logical_port_number,
    input wire logic tx_line_terminate_strobe,
    input wire logic tx_ram_drain_disable,
    output logic tx_partition_full_flag,
    input wire logic sched_pop,
    input wire logic [TPW_PSEL_W-1:0] sched_part,
    output logic sched_ready,
    output logic sched_line_valid,
    output logic [TPW_LINE_W-1:0] sched_line_data,
    output tpw_meta_t sched_line_meta,
    output logic sched_idle_insert
);

    localparam int LW = $clog2(LINES);
    localparam int AW = TPW_PSEL_W + LW;
    localparam logic [LW:0] LINES_C = (LW+1)'(LINES);
    localparam logic [LW:0] THRESH_C = (LW+1)'(FULL_THRESH);
    localparam logic [LW-1:0] LAST_LINE_C = LW'(LINES - 1);

    tpw_wr_t wr;
    logic [TPW_LANE_IDX_W-1:0] widx_q [TPW_PARTS];
    logic [LW-1:0] wptr_q [TPW_PARTS];
    logic [LW-1:0] rptr_q [TPW_PARTS];
    logic [LW:0] occ_q [TPW_PARTS];
    tpw_meta_t cur_meta_q [TPW_PARTS];
    tpw_meta_t meta_mem [2**AW];
    tpw_meta_t merged;
    logic no_room;
    logic mask_live;
    logic word_ok;
    logic commit;
    logic pop_ok;
    logic [TPW_LANES-1:0] lane_en;
    logic [AW-1:0] wr_addr;
    logic [AW-1:0] rd_addr;

    ////////////////////////////////////////////////////////////////////////////////
    // write request, everything taken on the rising edge of the write clock
    assign wr.part = tx_partition_select;
    assign wr.word = tx_write_word;
    assign wr.mask = tx_byte_valid_mask;
    assign wr.start = tx_packet_start_flag;
    assign wr.stop = tx_packet_end_flag;
    assign wr.err = tx_packet_error_flag;
    assign wr.port = tx_logical_port_number;

    ////////////////////////////////////////////////////////////////////////////////
    // qualify the request against the addressed partition
    // a partition with every line occupied drops the write instead of overwriting
    assign no_room = (occ_q[wr.part] == LINES_C);
    assign mask_live = (wr.mask != TPW_MASK_NONE);
    assign word_ok = tx_word_write_strobe && mask_live && !no_room;
    // fourth word, an end flag on any word, or a terminate closes the line
    assign commit = !no_room && ((tx_word_write_strobe && wr.stop)
                    || (word_ok && widx_q[wr.part] == TPW_LAST_LANE)
                    || tx_line_terminate_strobe);
    assign lane_en = word_ok ? TPW_LANES'(1) << widx_q[wr.part] : '0;
    assign wr_addr = {wr.part, wptr_q[wr.part]};

    ////////////////////////////////////////////////////////////////////////////////
    // descriptor of the line as it will be committed this cycle
    always_comb begin
        merged = cur_meta_q[wr.part];
        if (tx_word_write_strobe && !no_room) begin
            merged.port = wr.port;
            merged.start = merged.start | wr.start;
            merged.stop = wr.stop;
            merged.err = wr.err & wr.stop;
        end
        if (word_ok) begin
            merged.last_mask = wr.mask;
            merged.words = merged.words + TPW_WCNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // drain side: refused while disabled so every port of this ram waits
    assign sched_ready = !tx_ram_drain_disable && (occ_q[sched_part] != '0);
    assign pop_ok = sched_pop && sched_ready;
    assign rd_addr = {sched_part, rptr_q[sched_part]};

    ////////////////////////////////////////////////////////////////////////////////
    // per-partition pointers, word index, occupancy and open-line descriptor
    genvar p;
    generate
        for (p = 0; p < TPW_PARTS; p++) begin : g_part
            logic hit_w;
            logic hit_r;
            assign hit_w = (wr.part == TPW_PSEL_W'(p));
            assign hit_r = pop_ok && (sched_part == TPW_PSEL_W'(p));

            // word index and open descriptor restart at every commit
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    widx_q[p] <= '0;
                    cur_meta_q[p] <= '0;
                end else if (clk_en && hit_w) begin
                    if (commit) begin
                        widx_q[p] <= '0;
                        cur_meta_q[p] <= '0;
                    end else if (tx_word_write_strobe && !no_room) begin
                        widx_q[p] <= word_ok ? widx_q[p] + 2'h1 : widx_q[p];
                        cur_meta_q[p] <= merged;
                    end
                end
            end

            // write pointer wraps inside the partition's own line range
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    wptr_q[p] <= '0;
                end else if (clk_en && hit_w && commit) begin
                    wptr_q[p] <= (wptr_q[p] == LAST_LINE_C) ? '0 : wptr_q[p] + LW'(1);
                end
            end

            // read pointer moves only on an accepted pop
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    rptr_q[p] <= '0;
                end else if (clk_en && hit_r) begin
                    rptr_q[p] <= (rptr_q[p] == LAST_LINE_C) ? '0 : rptr_q[p] + LW'(1);
                end
            end

            // occupancy in lines; commit and pop together leave it unchanged
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    occ_q[p] <= '0;
                end else if (clk_en) begin
                    unique case ({hit_w && commit, hit_r})
                        2'b10: occ_q[p] <= occ_q[p] + (LW+1)'(1);
                        2'b01: occ_q[p] <= occ_q[p] - (LW+1)'(1);
                        default: occ_q[p] <= occ_q[p];
                    endcase
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // full flag for the presented address, one edge behind the select
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tx_partition_full_flag <= 1'b0;
        end else if (clk_en) begin
            tx_partition_full_flag <= (occ_q[wr.part] > THRESH_C);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // descriptor memory, written once per committed line
    always_ff @(posedge clk_sys) begin
        if (clk_en && commit) begin
            meta_mem[wr_addr] <= merged;
        end
    end

    // drained descriptor and valid arrive with the line data
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sched_line_meta <= '0;
            sched_line_valid <= 1'b0;
        end else if (clk_en) begin
            sched_line_valid <= pop_ok;
            if (pop_ok) begin
                sched_line_meta <= meta_mem[rd_addr];
            end
        end
    end

    // idle request toward the link follows the disable level
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sched_idle_insert <= 1'b0;
        end else if (clk_en) begin
            sched_idle_insert <= tx_ram_drain_disable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // word storage; word k of a line sits in lane k
    tpw_line_store #(
        .AW(AW),
        .LANES(TPW_LANES),
        .LANE_W(TPW_WORD_W)
    ) u_store (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .wr_en(word_ok),
        .wr_addr(wr_addr),
        .wr_lane_en(lane_en),
        .wr_word(wr.word),
        .rd_en(pop_ok),
        .rd_addr(rd_addr),
        .rd_line_q(sched_line_data)
    );

endmodule : tpw_write_port

/* File: testbench/tpw_write_port_sva.sv */
// assertion checker for the transmit partition write port
`timescale 1ns/1ps
module tpw_write_port_chk
    import tpw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic tx_word_write_strobe,
    input wire logic [TPW_PSEL_W-1:0] tx_partition_select,
    input wire logic tx_line_terminate_strobe,
    input wire logic tx_ram_drain_disable,
    input wire logic tx_partition_full_flag,
    input wire logic sched_pop,
    input wire logic sched_ready,
    input wire logic sched_line_valid,
    input wire logic sched_idle_insert,
    input wire tpw_meta_t sched_line_meta
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // drain side: disable gates every read, idle follows one edge late
    drain_block_a: assert property (tx_ram_drain_disable |-> !sched_ready)
        else $error("ready while drain disabled");
    idle_lag_a: assert property (clk_en
        |=> sched_idle_insert == $past(tx_ram_drain_disable)) else $error("idle lags disable");
    pop_cause_a: assert property ($rose(sched_line_valid)
        |-> $past(sched_pop && sched_ready && clk_en)) else $error("line out without pop");
    dis_quiet_a: assert property (tx_ram_drain_disable && clk_en
        |=> !sched_line_valid) else $error("line out while disabled");
    // full may only move when a commit, a pop or a new select explains it
    full_rise_a: assert property ($rose(tx_partition_full_flag) |->
        $past(tx_word_write_strobe || tx_line_terminate_strobe, 2) ||
        $past(tx_partition_select) != $past(tx_partition_select, 2)) else $error("full rose");
    full_fall_a: assert property ($fell(tx_partition_full_flag) |->
        $past(sched_pop && sched_ready, 2) ||
        $past(tx_partition_select) != $past(tx_partition_select, 2)) else $error("full fell");
    err_stop_a: assert property (sched_line_valid
        |-> sched_line_meta.stop || !sched_line_meta.err) else $error("error without end");
    line_words_a: assert property (sched_line_valid
        |-> sched_line_meta.words <= 3'h4) else $error("line word count too big");
    cover property (sched_pop && sched_ready);
    cover property ($rose(tx_partition_full_flag));
    cover property (tx_ram_drain_disable && sched_pop);
endmodule : tpw_write_port_chk

bind tpw_write_port tpw_write_port_chk chk (.*);

/* File: testbench/tpw_writer_model.sv */
// writer model: the fabric logic that feeds the write port
`timescale 1ns/1ps
module tpw_writer_model
    import tpw_pkg::*;
(
    input wire logic clk_sys,
    output tpw_wr_t wr,
    output logic strobe,
    output logic term
);
    // quiet bus at time zero
    initial begin
        wr = '0;
        strobe = 1'b0;
        term = 1'b0;
    end
    ////////////////////////////////////////
    // one word, held from just after an edge up to the sampling edge
    task automatic put(input logic [2:0] p, input logic [31:0] w, input logic [3:0] m,
                       input logic s, input logic e, input logic x, input logic [7:0] n);
        @(posedge clk_sys);
        #1;
        wr = '{p, w, m, s, e, x & e, n};
        strobe = 1'b1;
        term = 1'b0;
    endtask : put
    // released bus: flags drop, data flips so a stale word never passes
    task automatic idle(input logic [2:0] p, input logic t);
        @(posedge clk_sys);
        #1;
        wr = '{p, ~wr.word, wr.mask, 1'b0, 1'b0, 1'b0, wr.port};
        strobe = 1'b0;
        term = t;
    endtask : idle
    // start on the first word, end on the last, full lines of four between
    task automatic packet(input logic [2:0] p, input int n, input logic [31:0] b,
                          input logic [7:0] pt, input logic x, input logic [3:0] lm);
        for (int i = 0; i < n; i++) begin
            put(p, b + 32'(i), (i == n - 1) ? lm : TPW_MASK_ALL, i == 0, i == n - 1, x, pt);
        end
    endtask : packet
endmodule : tpw_writer_model

/* File: testbench/tb_top.sv */
// self-checking bench for the transmit partition write port
`timescale 1ns/1ps
module tb_top;
    import tpw_pkg::*;
    localparam logic [3:0] ENDM [3] = '{TPW_MASK_ALL, TPW_MASK_THREE, TPW_MASK_ONE};
    logic clk_sys, sys_rst, clk_en, strobe, term, dis, pop, ready, lval, full, idl;
    logic [2:0] ppart;
    logic [127:0] ldat;
    tpw_meta_t lmeta;
    tpw_wr_t wr;
    int fails, checked;
    logic [127:0] exp_d[8][$];
    tpw_meta_t exp_m[8][$];
    ////////////////////////////////////////
    // small partitions so full and refusal come quickly
    tpw_writer_model wrm (.clk_sys(clk_sys), .wr(wr), .strobe(strobe), .term(term));
    tpw_write_port #(.LINES(4), .FULL_THRESH(2)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .clk_en(clk_en), .tx_word_write_strobe(strobe), .tx_partition_select(wr.part),
        .tx_write_word(wr.word), .tx_byte_valid_mask(wr.mask), .tx_packet_start_flag(wr.start),
        .tx_packet_end_flag(wr.stop), .tx_packet_error_flag(wr.err),
        .tx_logical_port_number(wr.port), .tx_line_terminate_strobe(term),
        .tx_ram_drain_disable(dis), .tx_partition_full_flag(full), .sched_pop(pop),
        .sched_part(ppart), .sched_ready(ready), .sched_line_valid(lval),
        .sched_line_data(ldat), .sched_line_meta(lmeta), .sched_idle_insert(idl));
    // 200 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // descriptor of line l of an n-word packet
    function automatic tpw_meta_t exp_meta(int n, int l, logic [7:0] pt, logic x, logic [3:0] m);
        logic last;
        last = (4 * l + 4 >= n);
        return '{pt, l == 0, last, last & x, last ? m : TPW_MASK_ALL, 3'(last ? n - 4 * l : 4)};
    endfunction : exp_meta
    task automatic send(logic [2:0] p, int n, logic [7:0] pt, logic x, logic [3:0] m);
        logic [31:0] b;
        logic [127:0] d;
        b = $urandom;
        for (int l = 0; 4 * l < n; l++) begin
            d = '0;
            for (int k = 0; k < 4 && 4 * l + k < n; k++) d[32*k +: 32] = b + 32'(4 * l + k);
            exp_d[p].push_back(d);
            exp_m[p].push_back(exp_meta(n, l, pt, x, m));
        end
        wrm.packet(p, n, b, pt, x, m);
    endtask : send
    // one pop; a refused pop must leave the line output quiet
    task automatic drain(logic [2:0] p, logic want);
        logic [127:0] lanes;
        wrm.idle(p, 1'b0);
        pop = 1'b1;
        ppart = p;
        #1;
        check("ready", ready, want);
        @(posedge clk_sys);
        #1;
        pop = 1'b0;
        check("valid", lval, want);
        if (want) begin
            lanes = '0;
            for (int k = 0; k < exp_m[p][0].words; k++) lanes[32*k +: 32] = '1;
            check("data", ldat & lanes, exp_d[p].pop_front());
            check("meta", lmeta, exp_m[p].pop_front());
        end
    endtask : drain
    task automatic full_is(logic [2:0] p, logic want);
        wrm.idle(p, 1'b0);
        repeat (2) @(posedge clk_sys);
        #1;
        check("full", full, want);
    endtask : full_is
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // watchdog: tests need a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        wrap_up();
    end
    initial begin
        logic [2:0] p;
        logic [31:0] b;
        {clk_en, sys_rst, dis, pop, ppart, fails, checked} = {2'b11, 5'h0, 64'h0};
        void'($urandom(92215));
        repeat (8) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        send(3'h2, 4, 8'h05, 1'b0, TPW_MASK_ONE);
        drain(3'h2, 1'b1);
        for (int i = 0; i < 24; i++) begin
            p = 3'($urandom);
            send(p, int'(1 + $urandom % 7), 8'($urandom), 1'($urandom), ENDM[i % 3]);
            while (exp_m[p].size() > 0) drain(p, 1'b1);
        end
        $display("test walk and random packets done");
        // a dropped word must not take a lane of the next line
        wrm.put(3'h1, 32'hDEAD_BEEF, TPW_MASK_NONE, 1'b0, 1'b0, 1'b0, 8'h11);
        send(3'h1, 4, 8'h11, 1'b0, TPW_MASK_ALL);
        drain(3'h1, 1'b1);
        b = $urandom;
        exp_d[3].push_back({64'h0, b + 32'h1, b});
        exp_m[3].push_back(tpw_meta_t'{8'h22, 1'b1, 1'b0, 1'b0, TPW_MASK_ALL, 3'h2});
        wrm.put(3'h3, b, TPW_MASK_ALL, 1'b1, 1'b0, 1'b0, 8'h22);
        wrm.put(3'h3, b + 32'h1, TPW_MASK_ALL, 1'b0, 1'b0, 1'b0, 8'h22);
        wrm.idle(3'h3, 1'b1);
        drain(3'h3, 1'b1);
        // frozen clock enable: an ended word and a terminate must leave no line behind
        clk_en = 1'b0;
        wrm.put(3'h4, b, TPW_MASK_ALL, 1'b1, 1'b1, 1'b0, 8'h44);
        wrm.idle(3'h4, 1'b1);
        wrm.idle(3'h4, 1'b0);
        clk_en = 1'b1;
        drain(3'h4, 1'b0);
        $display("test dropped word and terminate done");
        dis = 1'b1;
        repeat (3) send(3'h5, 1, 8'h33, 1'b0, TPW_MASK_ALL);
        full_is(3'h5, 1'b1);
        full_is(3'h0, 1'b0);
        drain(3'h5, 1'b0);
        check("idle insert", idl, 1'b1);
        send(3'h5, 1, 8'h33, 1'b0, TPW_MASK_ALL);
        wrm.packet(3'h5, 1, 32'h0, 8'h33, 1'b0, TPW_MASK_ALL);
        full_is(3'h5, 1'b1);
        dis = 1'b0;
        repeat (4) drain(3'h5, 1'b1);
        drain(3'h5, 1'b0);
        check("idle insert", idl, 1'b0);
        $display("test drain disable done");
        wrap_up();
    end
endmodule : tb_top
